/* File: rtl/xba_arbiter.sv */
// External bus ownership: host hand-over, priority lines, DMA requests.
// Assumes one 40 MHz clock; pins are active high here, pads invert.
//
// Behaviour
// - Master finishes its outstanding transaction before granting to the host.
// - Master answers a host request by asserting host grant.
// - On hand-over, all bus outputs driven by the master are released.
// - On hand-over, the attached SDRAM is put into self-refresh.
// - Host grant stays asserted until the host drops its request.
// - Only the bus master drives host grant; slaves only monitor it.
// - Core priority line asserted while the core accesses external memory.
// - Slave core priority makes the master suspend background DMA.
// - Core priority line is open-drain: pull low or release only.
// - DMA priority line asserted while a high-priority channel accesses.
// - Slave DMA priority makes master's normal-priority DMA yield.
// - DMA priority line is open-drain: pull low or release only.
// - Four external DMA requests start transfers per channel setup.
// - Requests on uninitialised channels are ignored.
// - Flyby channels assert the flyby strobe during each flyby transfer.
// - I/O output enable active on flyby transfers from device to memory.
`timescale 1ns/1ps
`default_nettype none
`include "xba_defines.svh"

module xba_arbiter (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     resetn_i,
  // Mastership and host handshake
  input  wire logic                     is_master_i,
  input  wire logic                     host_request_i,
  input  wire logic                     host_grant_i,
  output logic                          host_grant_o,
  output logic                          host_grant_oe_o,
  // Transaction and SDRAM controller handshake
  input  wire logic                     xact_busy_i,
  output logic                          sdram_refresh_req_o,
  input  wire logic                     sdram_refresh_ack_i,
  output logic                          bus_drive_en_o,
  // Core and DMA engine status
  input  wire logic                     core_ext_access_i,
  input  wire logic                     hp_dma_access_i,
  input  wire logic                     np_dma_active_i,
  output logic                          bg_dma_suspend_o,
  output logic                          np_dma_yield_o,
  // Shared open-drain priority lines, high means pulled low
  input  wire logic                     core_priority_line_i,
  output logic                          core_priority_line_o,
  output logic                          core_priority_line_oe_o,
  input  wire logic                     dma_priority_line_i,
  output logic                          dma_priority_line_o,
  output logic                          dma_priority_line_oe_o,
  // External DMA requests and channel setup
  input  wire logic [`XBA_DMA_CH-1:0]   ext_dma_request_i,
  input  wire logic [`XBA_DMA_CH-1:0]   ch_init_i,
  input  wire logic [`XBA_DMA_CH-1:0]   ch_flyby_i,
  input  wire logic [`XBA_DMA_CH-1:0]   ch_io_to_mem_i,
  output logic [`XBA_DMA_CH-1:0]        dma_start_o,
  input  wire logic                     flyby_xfer_i,
  input  wire logic [1:0]               flyby_ch_i,
  output logic                          flyby_strobe_o,
  output logic                          io_dev_out_enable_o
);

  // ---------------------------------------------------------------
  // Host hand-over state machine
  // ---------------------------------------------------------------
  xba_pkg::xba_state_t state;
  xba_pkg::xba_state_t next_state;
  logic                host_req_s;
  logic                host_grant_s;

  xba_sync u_sync_hreq (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (host_request_i),
    .sync_o   (host_req_s)
  );

  xba_sync u_sync_hgnt (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (host_grant_i),
    .sync_o   (host_grant_s)
  );

  // The self-refresh handshake is done before the grant so that the host
  // never sees an SDRAM that still needs our refresh cycles.
  always_comb begin
    next_state = state;
    case (state)
      xba_pkg::XBA_SLAVE: begin
        if (is_master_i && !host_grant_s) next_state = xba_pkg::XBA_OWN;
      end
      xba_pkg::XBA_OWN: begin
        if (!is_master_i) next_state = xba_pkg::XBA_SLAVE;
        else if (host_req_s) next_state = xba_pkg::XBA_DRAIN;
      end
      xba_pkg::XBA_DRAIN: begin
        if (!xact_busy_i) next_state = xba_pkg::XBA_REFRESH;
      end
      xba_pkg::XBA_REFRESH: begin
        if (sdram_refresh_ack_i) next_state = xba_pkg::XBA_GRANTED;
      end
      xba_pkg::XBA_GRANTED: begin
        if (!host_req_s) next_state = xba_pkg::XBA_SLAVE;
      end
      default: next_state = xba_pkg::XBA_SLAVE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) state <= xba_pkg::XBA_SLAVE;
    else state <= next_state;
  end

  logic granted;
  logic owns_bus;
  assign granted = (state == xba_pkg::XBA_GRANTED);
  assign owns_bus = (state == xba_pkg::XBA_OWN)
                 || (state == xba_pkg::XBA_DRAIN)
                 || (state == xba_pkg::XBA_REFRESH);

  // ---------------------------------------------------------------
  // Pin outputs, registered
  // ---------------------------------------------------------------
  logic                    grant_q;
  logic                    grant_oe_q;
  logic                    drive_q;
  logic                    refresh_q;
  logic                    cpa_q;
  logic                    dpa_q;
  logic                    flyby_q;
  logic                    io_dev_out_enable_q;
  logic                    next_grant;
  logic                    next_grant_oe;
  logic                    next_drive;
  logic                    next_refresh;
  logic                    next_cpa;
  logic                    next_dpa;
  logic                    next_flyby;
  logic                    next_io_dev_out_enable;
  logic [1:0]              cpa_hist;
  logic [1:0]              dpa_hist;
  logic [1:0]              next_cpa_hist;
  logic [1:0]              next_dpa_hist;

  always_comb begin
    next_grant    = granted;
    next_grant_oe = is_master_i || granted;
    next_drive    = owns_bus;
    next_refresh  = (state == xba_pkg::XBA_REFRESH) || granted;
    next_cpa      = core_ext_access_i;
    next_dpa      = hp_dma_access_i;
    next_flyby    = flyby_xfer_i && ch_flyby_i[flyby_ch_i];
    next_io_dev_out_enable     = next_flyby && ch_io_to_mem_i[flyby_ch_i];
    next_cpa_hist = {cpa_hist[0], cpa_q};
    next_dpa_hist = {dpa_hist[0], dpa_q};
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      grant_q    <= `XBA_LINE_IDLE;
      grant_oe_q <= `XBA_LINE_IDLE;
      drive_q    <= `XBA_LINE_IDLE;
      refresh_q  <= `XBA_LINE_IDLE;
      cpa_q      <= `XBA_LINE_IDLE;
      dpa_q      <= `XBA_LINE_IDLE;
      flyby_q    <= `XBA_LINE_IDLE;
      io_dev_out_enable_q     <= `XBA_LINE_IDLE;
      cpa_hist   <= {2{`XBA_LINE_IDLE}};
      dpa_hist   <= {2{`XBA_LINE_IDLE}};
    end else begin
      grant_q    <= next_grant;
      grant_oe_q <= next_grant_oe;
      drive_q    <= next_drive;
      refresh_q  <= next_refresh;
      cpa_q      <= next_cpa;
      dpa_q      <= next_dpa;
      flyby_q    <= next_flyby;
      io_dev_out_enable_q     <= next_io_dev_out_enable;
      cpa_hist   <= next_cpa_hist;
      dpa_hist   <= next_dpa_hist;
    end
  end

  assign host_grant_o        = grant_q;
  assign host_grant_oe_o     = grant_oe_q;
  assign bus_drive_en_o      = drive_q;
  assign sdram_refresh_req_o = refresh_q;
  assign flyby_strobe_o      = flyby_q && drive_q;
  assign io_dev_out_enable_o = io_dev_out_enable_q && drive_q;

  // Open drain: the data bit is always the pulled level, only enable moves.
  assign core_priority_line_o    = `XBA_LINE_PULL;
  assign core_priority_line_oe_o = cpa_q;
  assign dma_priority_line_o     = `XBA_LINE_PULL;
  assign dma_priority_line_oe_o  = dpa_q;

  // ---------------------------------------------------------------
  // Priority preemption seen from the master
  // ---------------------------------------------------------------
  logic cpa_s;
  logic dpa_s;

  xba_sync u_sync_cpa (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (core_priority_line_i),
    .sync_o   (cpa_s)
  );

  xba_sync u_sync_dpa (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  (dma_priority_line_i),
    .sync_o   (dpa_s)
  );

  // Our own pull is masked for the synchroniser's lag as well, so a master
  // does not stall itself on a line that it has just released.
  assign bg_dma_suspend_o = owns_bus && cpa_s && !cpa_q
                         && !(|cpa_hist);
  assign np_dma_yield_o   = owns_bus && np_dma_active_i
                         && dpa_s && !dpa_q && !(|dpa_hist);

  // ---------------------------------------------------------------
  // External DMA requests
  // ---------------------------------------------------------------
  logic [`XBA_DMA_CH-1:0] dreq_s;
  logic [`XBA_DMA_CH-1:0] dreq_d;
  logic [`XBA_DMA_CH-1:0] next_dreq_d;
  logic [`XBA_DMA_CH-1:0] start_q;
  logic [`XBA_DMA_CH-1:0] next_start;

  genvar g;
  generate
    for (g = 0; g < `XBA_DMA_CH; g++) begin : g_dreq
      xba_sync u_sync_dreq (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .async_i  (ext_dma_request_i[g]),
        .sync_o   (dreq_s[g])
      );
    end
  endgenerate

  // A start pulse per rising request; edge is taken after the synchroniser.
  always_comb begin
    next_dreq_d = dreq_s;
    next_start  = dreq_s & ~dreq_d & ch_init_i;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dreq_d  <= {`XBA_DMA_CH{1'b0}};
      start_q <= {`XBA_DMA_CH{1'b0}};
    end else begin
      dreq_d  <= next_dreq_d;
      start_q <= next_start;
    end
  end

  assign dma_start_o = start_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_grant_after_drain: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (state == xba_pkg::XBA_DRAIN) && xact_busy_i
    |=> (state == xba_pkg::XBA_DRAIN) && !host_grant_o)
    else $error("grant given while a transaction was busy");

  chk_grant_holds: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    granted && host_req_s |=> granted)
    else $error("grant dropped while host still requests");

  chk_grant_answers: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    granted |=> host_grant_o && host_grant_oe_o)
    else $error("grant state not shown on pin");

  chk_release_bus: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_grant_o |-> !bus_drive_en_o && !flyby_strobe_o)
    else $error("bus driven while host granted");

  chk_refresh_first: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    host_grant_o |-> sdram_refresh_req_o)
    else $error("grant without self-refresh");

  chk_slave_quiet: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $past(!is_master_i && !granted) |-> !host_grant_oe_o)
    else $error("slave drives host grant");

  chk_cpa_follows: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    core_ext_access_i |=> core_priority_line_oe_o)
    else $error("core priority not pulled");

  chk_dpa_follows: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    hp_dma_access_i |=> dma_priority_line_oe_o)
    else $error("dma priority not pulled");

  chk_uninit_ignored: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    (dma_start_o & ~$past(ch_init_i)) == `XBA_CH_NONE)
    else $error("start on uninitialised channel");

  chk_io_dev_out_enable_flyby: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    io_dev_out_enable_o |-> flyby_strobe_o)
    else $error("io enable outside flyby");

endmodule : xba_arbiter
`default_nettype wire

/* File: rtl/xba_defines.svh */
// Constants of the external bus ownership block.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef XBA_DEFINES_SVH
`define XBA_DEFINES_SVH

`define XBA_DMA_CH      4
`define XBA_SYNC_RST    1'b0
`define XBA_LINE_IDLE   1'b0
`define XBA_LINE_PULL   1'b1
`define XBA_CH_NONE     4'h0

`endif

/* File: rtl/xba_pkg.sv */
// Types of the external bus ownership block.
// Assumes the defines header is compiled alongside.
package xba_pkg;

  typedef enum logic [4:0] {
    XBA_OWN     = 5'b0_0001,
    XBA_DRAIN   = 5'b0_0010,
    XBA_REFRESH = 5'b0_0100,
    XBA_GRANTED = 5'b0_1000,
    XBA_SLAVE   = 5'b1_0000
  } xba_state_t;

endpackage : xba_pkg

/* File: rtl/xba_sync.sv */
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input has no relation to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "xba_defines.svh"

module xba_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);

  logic stage1;
  logic stage2;
  logic next_stage1;
  logic next_stage2;

  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1 <= `XBA_SYNC_RST;
      stage2 <= `XBA_SYNC_RST;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;

endmodule : xba_sync
`default_nettype wire

/* File: bench/xba_far_model.sv */
// Far side of the bus ownership block: host, SDRAM controller, I/O device.
// Assumes active high levels and changes only on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module xba_far_model #(
  parameter int ACK_LAT = 3
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Host wish and SDRAM handshake
  input  wire logic want_bus_i,
  input  wire logic sdram_refresh_req_i,
  output logic      host_request_o,
  output logic      sdram_refresh_ack_o,
  // Flyby I/O device
  input  wire logic       flyby_strobe_i,
  output logic [3:0]      io_beats_o
);
  int cnt;

  // ----------------------------------------------------------------
  // Host request and self-refresh acknowledge
  // ----------------------------------------------------------------
  // The request follows the wish and is held for the whole ownership.
  always_ff @(negedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      host_request_o      <= 1'b0;
      sdram_refresh_ack_o <= 1'b0;
      cnt                 <= 0;
    end else begin
      host_request_o <= want_bus_i;
      if (!sdram_refresh_req_i) begin
        sdram_refresh_ack_o <= 1'b0;
        cnt                 <= 0;
      end else if (cnt >= ACK_LAT) begin
        sdram_refresh_ack_o <= 1'b1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end

  // The I/O device takes one data beat on every clock seen with the strobe.
  always_ff @(negedge clk_i or negedge resetn_i) begin
    if (!resetn_i) io_beats_o <= 4'h0;
    else if (flyby_strobe_i) io_beats_o <= io_beats_o + 4'h1;
  end
endmodule : xba_far_model
`default_nettype wire

/* File: bench/xba_arbiter_test.sv */
// Self-checking bench of the external bus ownership block.
// Assumes the far side model and inputs driven on the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "xba_defines.svh"

module xba_arbiter_test;
  logic clk_i = 1'b0, resetn_i = 1'b0, is_master_i = 1'b1, want = 1'b0;
  logic host_request_i, host_grant_i, host_grant_o, host_grant_oe_o;
  logic xact_busy_i = 1'b0, sdram_refresh_req_o, sdram_refresh_ack_i;
  logic bus_drive_en_o, bg_dma_suspend_o, np_dma_yield_o;
  logic core_ext_access_i = 1'b0, hp_dma_access_i = 1'b0;
  logic np_dma_active_i = 1'b1, peer_core = 1'b0, peer_dma = 1'b0;
  logic core_priority_line_i, core_priority_line_o, core_priority_line_oe_o;
  logic dma_priority_line_i, dma_priority_line_o, dma_priority_line_oe_o;
  logic [3:0] ext_dma_request_i = 4'h0, ch_init_i = 4'h0;
  logic [3:0] ch_flyby_i = 4'h0, ch_io_to_mem_i = 4'h0, dma_start_o;
  logic flyby_xfer_i = 1'b0, flyby_strobe_o, io_dev_out_enable_o;
  logic [1:0] flyby_ch_i = 2'h0;
  logic [3:0] io_beats;
  int err_total = 0, compares = 0;

  // ----------------------------------------------------------------
  // Clock, wires and instances
  // ----------------------------------------------------------------
  always #12.5 clk_i = ~clk_i;
  // Idle grant and priority wires read as released, not as stale data.
  assign host_grant_i = host_grant_oe_o & host_grant_o;
  assign core_priority_line_i = core_priority_line_oe_o | peer_core;
  assign dma_priority_line_i = dma_priority_line_oe_o | peer_dma;

  xba_far_model #(.ACK_LAT(3)) far (.clk_i(clk_i), .resetn_i(resetn_i),
    .want_bus_i(want), .sdram_refresh_req_i(sdram_refresh_req_o),
    .host_request_o(host_request_i),
    .sdram_refresh_ack_o(sdram_refresh_ack_i),
    .flyby_strobe_i(flyby_strobe_o), .io_beats_o(io_beats));

  xba_arbiter DUT (.clk_i(clk_i), .resetn_i(resetn_i),
    .is_master_i(is_master_i), .host_request_i(host_request_i),
    .host_grant_i(host_grant_i), .host_grant_o(host_grant_o),
    .host_grant_oe_o(host_grant_oe_o), .xact_busy_i(xact_busy_i),
    .sdram_refresh_req_o(sdram_refresh_req_o),
    .sdram_refresh_ack_i(sdram_refresh_ack_i),
    .bus_drive_en_o(bus_drive_en_o),
    .core_ext_access_i(core_ext_access_i),
    .hp_dma_access_i(hp_dma_access_i), .np_dma_active_i(np_dma_active_i),
    .bg_dma_suspend_o(bg_dma_suspend_o), .np_dma_yield_o(np_dma_yield_o),
    .core_priority_line_i(core_priority_line_i),
    .core_priority_line_o(core_priority_line_o),
    .core_priority_line_oe_o(core_priority_line_oe_o),
    .dma_priority_line_i(dma_priority_line_i),
    .dma_priority_line_o(dma_priority_line_o),
    .dma_priority_line_oe_o(dma_priority_line_oe_o),
    .ext_dma_request_i(ext_dma_request_i), .ch_init_i(ch_init_i),
    .ch_flyby_i(ch_flyby_i), .ch_io_to_mem_i(ch_io_to_mem_i),
    .dma_start_o(dma_start_o), .flyby_xfer_i(flyby_xfer_i),
    .flyby_ch_i(flyby_ch_i), .flyby_strobe_o(flyby_strobe_o),
    .io_dev_out_enable_o(io_dev_out_enable_o));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic chk(input string nm, input logic [3:0] seen,
                     input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // A slow transaction must delay the grant; the bus is freed only then.
  task automatic host_handover;
    xact_busy_i = 1'b1;
    want = 1'b1;
    cyc(10);
    chk("grant_busy", host_grant_o, 0);
    chk("refresh_busy", sdram_refresh_req_o, 0);
    xact_busy_i = 1'b0;
    for (int i = 0; i < 12 && host_grant_o !== 1'b1; i++) cyc(1);
    chk("grant", host_grant_o, 1);
    chk("grant_oe", host_grant_oe_o, 1);
    chk("drive_off", bus_drive_en_o, 0);
    chk("self_refresh", sdram_refresh_req_o, 1);
    cyc(20);
    chk("grant_held", host_grant_o, 1);
    want = 1'b0;
    for (int i = 0; i < 8 && host_grant_o !== 1'b0; i++) cyc(1);
    chk("grant_drop", host_grant_o, 0);
    for (int i = 0; i < 8 && bus_drive_en_o !== 1'b1; i++) cyc(1);
    chk("drive_back", bus_drive_en_o, 1);
  endtask : host_handover

  task automatic slave_role;
    is_master_i = 1'b0;
    cyc(4);
    chk("slave_grant_oe", host_grant_oe_o, 0);
    chk("slave_drive", bus_drive_en_o, 0);
    is_master_i = 1'b1;
    cyc(6);
    chk("master_drive", bus_drive_en_o, 1);
  endtask : slave_role

  // Own pulls must not suspend us; a peer's pull must.
  task automatic priority_lines;
    core_ext_access_i = 1'b1;
    hp_dma_access_i = 1'b1;
    cyc(4);
    chk("core_pull", core_priority_line_oe_o, 1);
    chk("core_val", core_priority_line_o, 1);
    chk("dma_pull", dma_priority_line_oe_o, 1);
    chk("dma_val", dma_priority_line_o, 1);
    chk("self_suspend", bg_dma_suspend_o, 0);
    core_ext_access_i = 1'b0;
    hp_dma_access_i = 1'b0;
    cyc(2);
    chk("core_free", core_priority_line_oe_o, 0);
    chk("dma_free", dma_priority_line_oe_o, 0);
    chk("release_suspend", bg_dma_suspend_o, 0);
    chk("release_yield", np_dma_yield_o, 0);
    peer_core = 1'b1;
    peer_dma = 1'b1;
    cyc(4);
    chk("suspend", bg_dma_suspend_o, 1);
    chk("yield", np_dma_yield_o, 1);
    peer_core = 1'b0;
    peer_dma = 1'b0;
    cyc(4);
    chk("resume", bg_dma_suspend_o, 0);
    chk("no_yield", np_dma_yield_o, 0);
  endtask : priority_lines

  // A held request on an initialised channel starts exactly once.
  task automatic dma_requests;
    int n;
    for (int k = 0; k < 8; k++) begin
      n = 0;
      ch_init_i = (k < 4) ? 4'h0 : 4'hF;
      ext_dma_request_i = 4'h1 << (k % 4);
      repeat (10) begin
        cyc(1);
        n += int'(dma_start_o[k % 4] === 1'b1);
      end
      chk("dma_starts", 4'(n), (k < 4) ? 4'h0 : 4'h1);
      ext_dma_request_i = 4'h0;
      cyc(4);
    end
  endtask : dma_requests

  task automatic flyby;
    for (int m = 0; m < 2; m++) begin
      ch_flyby_i = 4'h4;
      ch_io_to_mem_i = (m == 1) ? 4'h4 : 4'h0;
      flyby_ch_i = 2'h2;
      flyby_xfer_i = 1'b1;
      cyc(3);
      chk("strobe", flyby_strobe_o, 1);
      chk("io_enable", io_dev_out_enable_o, 4'(m));
      flyby_xfer_i = 1'b0;
      cyc(3);
      chk("strobe_off", flyby_strobe_o, 0);
    end
    chk("io_beats", io_beats, 4'h6);
  endtask : flyby

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    resetn_i = 1'b1;
    cyc(1);
    chk("reset_grant", host_grant_o, 0);
    cyc(8);
    chk("own_drive", bus_drive_en_o, 1);
    host_handover();
    slave_role();
    priority_lines();
    dma_requests();
    flyby();
    test_done();
  end

  // The sequence needs well under 1000 cycles.
  initial begin
    #(25 * 5000);
    err_total++;
    test_done();
  end
endmodule : xba_arbiter_test
`default_nettype wire
